// file: core/rco_regs.vh
// Reset values, field widths and codes of the reference clock output
`ifndef RCO_REGS_VH
`define RCO_REGS_VH

// Number of selectable clock sources and width of the source field
`define RCO_SRC_N 4
`define RCO_SRC_W 2
`define RCO_SRC_RST 2'h0

// Divider field: code n divides by two to the n
`define RCO_DIV_W 3
`define RCO_DIV_RST 3'h0
`define RCO_DIV_BYPASS 3'h0

// Duty field codes; upper bit resets to one for 50 percent
`define RCO_DUTY_W 2
`define RCO_DUTY_RST 2'h2
`define RCO_DUTY_OFF 2'h0
`define RCO_DUTY_25 2'h1
`define RCO_DUTY_50 2'h2
`define RCO_DUTY_75 2'h3

// Enable bit reset value
`define RCO_EN_RST 1'b0

// Half-period counter width, covers 2 * 128 half periods
`define RCO_CNT_W 8

`endif

// file: core/rco_div.v
// Half-period counter for the reference clock divider
`timescale 1ns/10ps
`include "rco_regs.vh"

module rco_div (
  input wire sys_clk,
  input wire rst_n,
  input wire hold,
  input wire clear,
  input wire step,
  input wire [`RCO_DIV_W-1:0] div_sel,
  output wire [`RCO_CNT_W-1:0] cnt
);

  reg [`RCO_CNT_W-1:0] cnt_r;
  reg [`RCO_CNT_W-1:0] cnt_nxt;
  wire [`RCO_CNT_W-1:0] wrap_mask;

  // Period is 2^(n+1) half periods of the source
  assign wrap_mask = {{(`RCO_CNT_W-1){1'b0}}, 1'b1} << div_sel;

  always @* begin
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = {`RCO_CNT_W{1'b0}};
    end else if (step) begin
      cnt_nxt = (cnt_r + 8'h01) & ((wrap_mask << 1) - 8'h01);
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= {`RCO_CNT_W{1'b0}};
    end else if (!hold) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt = cnt_r;

endmodule // rco_div

// file: core/rco_top.v
// Reference clock output: source select, divider, duty shaping
//
// Contract
// - Output clock source comes from the source-selection register.
// - Enabling starts output at a source rising edge, no runt pulse.
// - Clearing enable drops the output at once, mid-period.
// - Three-bit divider gives undivided and divide by 2 up to 128.
// - Two-bit duty field gives 25, 50 or 75 percent high time.
// - Undivided setting passes the source through; duty is ignored.
// - Duty field resets to binary 10, giving 50 percent.
// - Runs on system clock; output holds its level during sleep.
// - Settings, edge tracking and generator state stay unaltered across sleep; the source synchronisers keep sampling.
`timescale 1ns/10ps
`include "rco_regs.vh"

module rco_top (
  input wire sys_clk,
  input wire rst_n,
  input wire [`RCO_SRC_N-1:0] src_clk_in,
  input wire sleep_active,
  input wire src_wr,
  input wire [`RCO_SRC_W-1:0] src_wdata,
  input wire ctrl_wr,
  input wire ctrl_en_wdata,
  input wire [`RCO_DIV_W-1:0] ctrl_div_wdata,
  input wire [`RCO_DUTY_W-1:0] ctrl_duty_wdata,
  output wire [`RCO_SRC_W-1:0] ref_source_select_reg,
  output wire ref_output_enable_bit,
  output wire [`RCO_DIV_W-1:0] div_select_field,
  output wire [`RCO_DUTY_W-1:0] duty_select_field,
  output wire ref_clk_out,
  output wire ref_clk_oe,
  output wire ref_running
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ARM = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  // Settings
  reg [`RCO_SRC_W-1:0] src_sel_r;
  reg en_r;
  reg [`RCO_DIV_W-1:0] div_r;
  reg [`RCO_DUTY_W-1:0] duty_r;

  // Source synchronisers and edge tracking
  reg [`RCO_SRC_N-1:0] src_meta_r;
  reg [`RCO_SRC_N-1:0] src_sync_r;
  reg src_prev_r;
  wire src_lvl;
  wire src_rise;
  wire src_fall;
  wire src_edge;

  // Generator
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg out_r;
  reg out_nxt;
  reg cnt_clear;
  reg cnt_step;
  wire [`RCO_CNT_W-1:0] cnt;
  wire [`RCO_CNT_W-1:0] cnt_after;
  wire stop_now;

  // High time in half periods for a divider code and duty code
  function [`RCO_CNT_W-1:0] high_len;
    input [`RCO_DIV_W-1:0] dv;
    input [`RCO_DUTY_W-1:0] dc;
    reg [`RCO_CNT_W-1:0] quarter;
    begin
      quarter = {{(`RCO_CNT_W-1){1'b0}}, 1'b1} << (dv - 3'h1);
      case (dc)
        `RCO_DUTY_25: high_len = quarter;
        `RCO_DUTY_50: high_len = quarter << 1;
        `RCO_DUTY_75: high_len = (quarter << 1) + quarter;
        default: high_len = {`RCO_CNT_W{1'b0}};
      endcase
    end
  endfunction

  // Count mask for one period of 2^(n+1) half periods; 4-bit shift for n=7
  function [`RCO_CNT_W-1:0] period_mask;
    input [`RCO_DIV_W-1:0] dv;
    begin
      period_mask = ({{(`RCO_CNT_W-1){1'b0}}, 1'b1} <<
        ({1'b0, dv} + 4'h1)) - 8'h01;
    end
  endfunction

  // Setting registers; writes are ignored while asleep
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      src_sel_r <= `RCO_SRC_RST;
      en_r <= `RCO_EN_RST;
      div_r <= `RCO_DIV_RST;
      duty_r <= `RCO_DUTY_RST;
    end else if (!sleep_active) begin
      if (src_wr) begin
        src_sel_r <= src_wdata;
      end
      if (ctrl_wr) begin
        en_r <= ctrl_en_wdata;
        // Taken even while enabled; may glitch the output
        div_r <= ctrl_div_wdata;
        duty_r <= ctrl_duty_wdata;
      end
    end
  end

  // Two-flop synchronisers on every source pin
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      src_meta_r <= {`RCO_SRC_N{1'b0}};
      src_sync_r <= {`RCO_SRC_N{1'b0}};
    end else begin
      src_meta_r <= src_clk_in;
      src_sync_r <= src_meta_r;
    end
  end

  assign src_lvl = src_sync_r[src_sel_r];

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      src_prev_r <= 1'b0;
    end else if (!sleep_active) begin
      src_prev_r <= src_lvl;
    end
  end

  assign src_rise = src_lvl & ~src_prev_r;
  assign src_fall = ~src_lvl & src_prev_r;
  assign src_edge = src_rise | src_fall;

  rco_div i_rco_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .hold(sleep_active),
    .clear(cnt_clear),
    .step(cnt_step),
    .div_sel(div_r),
    .cnt(cnt)
  );

  // Count value after the step taken on this edge
  assign cnt_after = (cnt + 8'h01) & period_mask(div_r);

  // A clearing write stops the pin on its own edge, not a cycle later
  assign stop_now = ~en_r | (ctrl_wr & ~ctrl_en_wdata & ~sleep_active);

  always @* begin
    state_nxt = state_r;
    out_nxt = out_r;
    cnt_clear = 1'b0;
    cnt_step = 1'b0;
    case (state_r)
      ST_IDLE: begin
        out_nxt = 1'b0;
        cnt_clear = 1'b1;
        if (en_r) begin
          state_nxt = ST_ARM;
        end
      end
      ST_ARM: begin
        out_nxt = 1'b0;
        cnt_clear = 1'b1;
        if (stop_now) begin
          state_nxt = ST_IDLE;
        end else if (src_rise) begin
          // First high phase starts on a whole source edge
          state_nxt = ST_RUN;
          if (div_r == `RCO_DIV_BYPASS) begin
            out_nxt = 1'b1;
          end else begin
            out_nxt = (high_len(div_r, duty_r) != 8'h00);
          end
        end
      end
      ST_RUN: begin
        if (stop_now) begin
          state_nxt = ST_IDLE;
          out_nxt = 1'b0;
          cnt_clear = 1'b1;
        end else if (div_r == `RCO_DIV_BYPASS) begin
          out_nxt = src_lvl;
        end else if (src_edge) begin
          cnt_step = 1'b1;
          // High while the count is below the duty length
          out_nxt = (cnt_after < high_len(div_r, duty_r));
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        out_nxt = 1'b0;
        cnt_clear = 1'b1;
      end
    endcase
  end

  // Sleep freezes the generator, so the pin keeps its level
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      out_r <= 1'b0;
    end else if (!sleep_active) begin
      state_r <= state_nxt;
      out_r <= out_nxt;
    end
  end

  assign ref_source_select_reg = src_sel_r;
  assign ref_output_enable_bit = en_r;
  assign div_select_field = div_r;
  assign duty_select_field = duty_r;
  assign ref_clk_out = out_r;
  assign ref_clk_oe = en_r;
  assign ref_running = (state_r == ST_RUN);

endmodule // rco_top

// file: tb/rco_top_chk.sv
// Port checker of the reference clock output
`timescale 1ns/10ps
`include "rco_regs.vh"
module rco_top_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire sleep_active,
  input wire src_wr,
  input wire [`RCO_SRC_W-1:0] src_wdata,
  input wire ctrl_wr,
  input wire ctrl_en_wdata,
  input wire [`RCO_DIV_W-1:0] ctrl_div_wdata,
  input wire [`RCO_DUTY_W-1:0] ctrl_duty_wdata,
  input wire [`RCO_SRC_W-1:0] ref_source_select_reg,
  input wire ref_output_enable_bit,
  input wire [`RCO_DIV_W-1:0] div_select_field,
  input wire [`RCO_DUTY_W-1:0] duty_select_field,
  input wire ref_clk_out,
  input wire ref_clk_oe,
  input wire ref_running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire ok = !sleep_active;
  sequence s_en_on;
    $rose(ref_output_enable_bit);
  endsequence
  sequence s_run;
    ##[1:40] $rose(ref_running);
  endsequence
  AST_RST: assert property ($rose(rst_n) |->
    duty_select_field == 2'h2 && !ref_running) else $error("bad reset");
  AST_START: assert property (s_en_on |-> s_run)
    else $error("no start");
  AST_FIRST: assert property ($rose(ref_running) |->
    ref_clk_out || duty_select_field == 2'h0) else $error("runt start");
  AST_OFF: assert property (ctrl_wr && ok && !ctrl_en_wdata |=>
    !ref_clk_out && !ref_clk_oe) else $error("late stop");
  AST_IDLE: assert property (!ref_output_enable_bit |->
    !ref_clk_out && !ref_clk_oe) else $error("drive while off");
  AST_SRC: assert property (src_wr && ok |=>
    ref_source_select_reg == $past(src_wdata)) else $error("bad src");
  AST_WR: assert property (ctrl_wr && ok |=>
    div_select_field == $past(ctrl_div_wdata) &&
    duty_select_field == $past(ctrl_duty_wdata)) else $error("bad ctrl");
  AST_SLP: assert property (sleep_active |=>
    $stable(ref_clk_out) && $stable(ref_running) &&
    $stable(div_select_field)) else $error("sleep change");
  AST_LOW: assert property (
    (div_select_field != 3'h0 && duty_select_field == 2'h0) [*2] |->
    !ref_clk_out) else $error("duty off high");
endmodule // rco_top_chk

// file: tb/rco_sink.sv
// Clock consumer measuring high pulse lengths
`timescale 1ns/10ps
module rco_sink (
  input wire sys_clk,
  input wire ref_clk_out,
  output int hi_len,
  output int falls
);
  int cnt = 0;
  initial falls = 0;
  always @(posedge sys_clk) begin
    cnt <= ref_clk_out ? cnt + 1 : 0;
    if (!ref_clk_out && cnt != 0) begin
      hi_len <= cnt;
      falls <= falls + 1;
    end
  end
endmodule // rco_sink

// file: tb/rco_top_tb.sv
// Testbench of the reference clock output
`timescale 1ns/10ps
`include "rco_regs.vh"
module rco_top_tb;
  logic sys_clk = 0, rst_n = 0, sleep_active = 0, src_wr = 0;
  logic ctrl_wr = 0, ctrl_en_wdata = 0;
  logic [`RCO_SRC_N-1:0] src_clk_in = 0;
  logic [1:0] src_wdata = 0, ctrl_duty_wdata = 0, d, s;
  logic [2:0] ctrl_div_wdata = 0, n;
  wire [1:0] ref_source_select_reg, duty_select_field;
  wire [2:0] div_select_field;
  wire ref_output_enable_bit, ref_clk_out, ref_clk_oe, ref_running;
  int hi_len, falls, cyc = 0, num_errors = 0, total_checks = 0;
  int e, f, k, i;
  rco_top i_rco_top (.*);
  rco_sink i_rco_sink (.*);
  always #10 sys_clk = ~sys_clk;
  // Source j stays j+3 cycles in each level
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    for (int j = 0; j < `RCO_SRC_N; j++)
      if (cyc % (j + 3) == 0) src_clk_in[j] <= ~src_clk_in[j];
    if (cyc > 60000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] x, g);
    total_checks++;
    if (g !== x) begin
      $display("unexpected %s expected %0d seen %0d", nm, x, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic en, input logic [2:0] dv,
                    input logic [1:0] dc, sr);
    @(negedge sys_clk);
    ctrl_wr = 1;
    src_wr = 1;
    ctrl_en_wdata = en;
    ctrl_div_wdata = dv;
    ctrl_duty_wdata = dc;
    src_wdata = sr;
    @(negedge sys_clk);
    ctrl_wr = 0;
    src_wr = 0;
  endtask
  task automatic pulse;
    f = falls;
    for (k = 0; k < 4000 && falls == f; k++) @(negedge sys_clk);
    chk("high time", e[15:0], hi_len[15:0]);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hba8dec84));
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    @(negedge sys_clk);
    chk("duty", 8'h02, duty_select_field);
    for (i = 0; i < 10; i++) begin
      n = 3'(i);
      d = (i == 0) ? 2'h0 : 2'($urandom_range(3, 1));
      s = 2'($urandom_range(3));
      wr(0, n, d, s);
      wr(1, n, d, s);
      e = (n == 0) ? s + 3 : ((s + 3) * d) << (n - 1);
      pulse();
      chk("oe", 1, ref_clk_oe);
      pulse();
      sleep_active = 1;
      wr(1, 0, 0, 0);
      chk("div", n, div_select_field);
      repeat (20) @(negedge sys_clk);
      sleep_active = 0;
      for (k = 0; k < 4000 && ref_clk_out !== 1; k++) @(negedge sys_clk);
      wr(0, n, d, s);
      chk("out", 0, {ref_clk_oe, ref_clk_out});
    end
    wr(1, 1, 0, 0);
    f = falls;
    repeat (60) @(negedge sys_clk);
    chk("falls", f[7:0], falls[7:0]);
    end_sim();
  end
endmodule // rco_top_tb
bind rco_top rco_top_chk i_rco_top_chk (.*);
